//--- dcis_top.sv
// dcis_top: two-channel drive command sequencer with status words and bus slave
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Operation
// - completion flag stands for exactly one program scan after a command ends
// - completion flag pulses also when the command ended in a drive error
// - serial error flag sets on any communication error on the channel
// - busy flag stays high for the whole drive transfer on the channel
// - a drive error sets both the drive error flag and its latch
// - bulk-write command failure sets the bulk-write error flag
// - serial flag, serial code and response wait time clear only at power-up
// - stop-to-run clears drive flags, latch, bulk flag, drive code, error step and parameter
// - serial error code word holds the latest serial error
// - response wait time is read-write; all other words are read-only
// - active step word shows the step of the command being executed
// - drive error code word holds the latest drive error code
// - first error step is caught on the first error only until cleared
// - failing bulk write stores the failing parameter number
// - mode word reports the communication type in use
// - six command types with consecutive function codes
// - each command type has its fixed transfer direction
// - a transfer begins on the rising edge of the drive condition
// - a started transfer completes even if its drive condition drops
// - a command held driven repeats its transfer
// - commands driven together run one at a time in slot order after the last slot run, wrapping
// - wait 15 ms after taking the port before the transfer starts
// - line errors set only the serial flag and the per-channel line code
module dcis_top
   import dcis_pkg::*;
#(
   parameter int PORT_WAIT_CYC = PORT_WAIT_CYC_DEF
) (
   // clock and reset
   input  wire logic                                  ref_clk_i,
   input  wire logic                                  sys_rst_i,
   // program scan
   input  wire logic                                  run_mode_i,
   input  wire logic                                  scan_end_i,
   input  wire logic [NCH-1:0][NSLOT-1:0]             drive_i,
   input  wire dcis_cmd_t [NCH-1:0][NSLOT-1:0]        cmd_kind_i,
   input  wire logic [NCH-1:0][NSLOT-1:0][15:0]       cmd_step_i,
   // transfer engine
   input  wire logic [NCH-1:0]                        xfer_done_i,
   input  wire logic [NCH-1:0]                        xfer_err_i,
   input  wire logic [NCH-1:0][15:0]                  xfer_err_code_i,
   input  wire logic [NCH-1:0][15:0]                  xfer_err_param_i,
   input  wire logic [NCH-1:0]                        line_err_i,
   output logic      [NCH-1:0]                        xfer_req_o,
   output dcis_cmd_t [NCH-1:0]                        xfer_kind_o,
   output logic      [NCH-1:0][15:0]                  xfer_func_o,
   output logic      [NCH-1:0][1:0]                   xfer_dir_o,
   output logic      [NCH-1:0][15:0]                  resp_wait_o,
   // status flags
   output logic                                       done_o,
   output logic      [NCH-1:0]                        ser_err_o,
   output logic      [NCH-1:0]                        busy_o,
   output logic      [NCH-1:0]                        drv_err_o,
   output logic      [NCH-1:0]                        drv_err_latch_o,
   output logic      [NCH-1:0]                        bulk_err_o,
   // avalon-mm slave
   input  wire logic [5:0]                            avs_address,
   input  wire logic                                  avs_read,
   input  wire logic                                  avs_write,
   input  wire logic [31:0]                           avs_writedata,
   input  wire logic [3:0]                            avs_byteenable,
   output logic      [31:0]                           avs_readdata,
   output logic                                       avs_waitrequest
);

   typedef struct packed {
      dcis_state_t           state;
      logic [TMR_W-1:0]      tmr;
      logic [NSLOT-1:0]      pend;
      logic [NSLOT-1:0]      drv_prev;
      logic [SLW-1:0]        cur;
      dcis_cmd_t             kind;
      logic [15:0]           func;
      logic [1:0]            dir;
      logic                  req;
      logic                  busy;
      logic                  ser_err;
      logic                  drv_err;
      logic                  drv_lat;
      logic                  bulk_err;
      logic [15:0]           ser_code;
      logic [15:0]           resp_wait;
      logic [15:0]           act_step;
      logic [15:0]           drv_code;
      logic [15:0]           err_step;
      logic [15:0]           bulk_param;
      logic [15:0]           mode;
   } dcis_chan_t;

   typedef struct packed {
      dcis_chan_t [NCH-1:0]  ch;
      logic                  run_prev;
      logic                  done_pend;
      logic                  done;
      logic                  wait_n;
      logic [31:0]           rdata;
   } dcis_state_all_t;

   dcis_state_all_t q_q;
   dcis_state_all_t q_d;

   // next pending slot in program order after the current one, wrapping
   function automatic logic [SLW:0] pick_next(input logic [NSLOT-1:0] pend,
                                             input logic [SLW-1:0]   cur);
      logic [SLW:0]   res;
      logic [SLW-1:0] idx;
      res = '0;
      idx = '0;
      for (int k = NSLOT; k >= 1; k--) begin
         idx = SLW'(cur + SLW'(k));
         if (pend[idx]) begin
            res = {1'b1, idx};
         end
      end
      return res;
   endfunction

   // fixed transfer direction per command type
   function automatic logic [1:0] cmd_dir(input dcis_cmd_t k);
      logic [1:0] d;
      d = '0;
      unique case (k)
         CMD_MONITOR, CMD_PARAM_READ:                  d[DIR_FROM_DRIVE] = 1'b1;
         CMD_CONTROL, CMD_PARAM_WRITE, CMD_BULK_WRITE: d[DIR_TO_DRIVE] = 1'b1;
         CMD_CTRL_MONITOR:                             d = 2'b11;
         default:                                      d = '0;
      endcase
      return d;
   endfunction

   function automatic logic [15:0] be_merge(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   localparam logic [TMR_W-1:0] PORT_LAST = TMR_W'(PORT_WAIT_CYC - 1);

   always_comb begin
      logic              run_rise;
      logic [SLW:0]      nx;
      logic [NSLOT-1:0]  rise;
      logic              hit;
      logic [4:0]        off;
      logic [31:0]       rd;
      dcis_cmd_t         kind;
      run_rise = 1'b0;
      nx       = '0;
      rise     = '0;
      hit      = 1'b0;
      off      = '0;
      rd       = '0;
      kind     = CMD_MONITOR;
      q_d      = q_q;

      run_rise    = run_mode_i & ~q_q.run_prev;
      q_d.run_prev = run_mode_i;

      // the done flag follows the scan boundary so it spans one full scan
      if (scan_end_i) begin
         q_d.done      = q_q.done_pend;
         q_d.done_pend = 1'b0;
      end

      for (int c = 0; c < NCH; c++) begin
         // clears come first so that a same-cycle event still sets its flag
         if (run_rise) begin
            q_d.ch[c].drv_err    = 1'b0;
            q_d.ch[c].drv_lat    = 1'b0;
            q_d.ch[c].bulk_err   = 1'b0;
            q_d.ch[c].drv_code   = WORD_RST;
            q_d.ch[c].err_step   = WORD_RST;
            q_d.ch[c].bulk_param = WORD_RST;
         end

         rise = drive_i[c] & ~q_q.ch[c].drv_prev;
         q_d.ch[c].drv_prev = drive_i[c];
         if (run_mode_i) begin
            q_d.ch[c].pend = q_d.ch[c].pend | rise;
         end

         unique case (q_q.ch[c].state)
            ST_IDLE: begin
               nx = pick_next(q_d.ch[c].pend, q_q.ch[c].cur);
               if (nx[SLW]) begin
                  q_d.ch[c].cur                = nx[SLW-1:0];
                  q_d.ch[c].pend[nx[SLW-1:0]]  = 1'b0;
                  q_d.ch[c].busy               = 1'b1;
                  q_d.ch[c].tmr                = '0;
                  q_d.ch[c].state              = ST_PORT;
                  q_d.ch[c].act_step = cmd_step_i[c][nx[SLW-1:0]];
                  q_d.ch[c].mode               = MODE_DRIVE;
                  // kind is held from selection so a later edit cannot alter a live transfer
                  kind                         = cmd_kind_i[c][nx[SLW-1:0]];
                  q_d.ch[c].kind               = kind;
                  q_d.ch[c].func               = FUNC_CODE_BASE + 16'(kind);
                  q_d.ch[c].dir                = cmd_dir(kind);
               end
            end
            ST_PORT: begin
               q_d.ch[c].tmr = TMR_W'(q_q.ch[c].tmr + 1'b1);
               if (q_q.ch[c].tmr >= PORT_LAST) begin
                  q_d.ch[c].state = ST_XFER;
                  q_d.ch[c].req   = 1'b1;
               end
            end
            ST_XFER: begin
               // drive condition is read here only to re-queue a held command, so a drop never aborts
               if (xfer_done_i[c]) begin
                  q_d.ch[c].req   = 1'b0;
                  q_d.ch[c].busy  = 1'b0;
                  q_d.ch[c].state = ST_IDLE;
                  q_d.done_pend   = 1'b1;
                  q_d.ch[c].drv_err = xfer_err_i[c];
                  kind = q_q.ch[c].kind;
                  if (xfer_err_i[c]) begin
                     q_d.ch[c].drv_lat  = 1'b1;
                     q_d.ch[c].ser_err  = 1'b1;
                     q_d.ch[c].ser_code = xfer_err_code_i[c];
                     q_d.ch[c].drv_code = xfer_err_code_i[c];
                     if (!q_q.ch[c].drv_lat || run_rise) begin
                        q_d.ch[c].err_step = q_q.ch[c].act_step;
                     end
                     if (kind == CMD_BULK_WRITE) begin
                        q_d.ch[c].bulk_err   = 1'b1;
                        q_d.ch[c].bulk_param = xfer_err_param_i[c];
                     end
                  end
                  if (drive_i[c][q_q.ch[c].cur] && run_mode_i) begin
                     q_d.ch[c].pend[q_q.ch[c].cur] = 1'b1;
                  end
               end
            end
            default: begin
               q_d.ch[c].state = ST_IDLE;
            end
         endcase

         // framing, parity or overrun: serial flag and line code only
         if (line_err_i[c]) begin
            q_d.ch[c].ser_err  = 1'b1;
            q_d.ch[c].ser_code = (c == 0) ? LINE_ERR_CODE_CH1 : LINE_ERR_CODE_CH2;
         end
      end

      // bus slave: one wait cycle, then the access completes
      hit = avs_read | avs_write;
      q_d.wait_n = hit & ~q_q.wait_n;
      for (int c = 0; c < NCH; c++) begin
         if (avs_address[5] == c[0]) begin
            off = avs_address[4:0];
            unique case (off)
               OFF_STATUS: begin
                  rd[ST_BIT_DONE]     = q_q.done;
                  rd[ST_BIT_SER_ERR]  = q_q.ch[c].ser_err;
                  rd[ST_BIT_BUSY]     = q_q.ch[c].busy;
                  rd[ST_BIT_DRV_ERR]  = q_q.ch[c].drv_err;
                  rd[ST_BIT_DRV_LAT]  = q_q.ch[c].drv_lat;
                  rd[ST_BIT_BULK_ERR] = q_q.ch[c].bulk_err;
               end
               OFF_SER_CODE:   rd[15:0] = q_q.ch[c].ser_code;
               OFF_RESP_WAIT:  rd[15:0] = q_q.ch[c].resp_wait;
               OFF_ACT_STEP:   rd[15:0] = q_q.ch[c].act_step;
               OFF_DRV_CODE:   rd[15:0] = q_q.ch[c].drv_code;
               OFF_ERR_STEP:   rd[15:0] = q_q.ch[c].err_step;
               OFF_BULK_PARAM: rd[15:0] = q_q.ch[c].bulk_param;
               OFF_MODE:       rd[15:0] = q_q.ch[c].mode;
               default:        rd = '0;
            endcase
            // only the wait time word takes writes; the rest ignore them
            if (avs_write && q_q.wait_n && off == OFF_RESP_WAIT) begin
               q_d.ch[c].resp_wait = be_merge(q_q.ch[c].resp_wait,
                                              avs_writedata, avs_byteenable);
            end
         end
      end
      if (avs_read && !q_q.wait_n) begin
         q_d.rdata = rd;
      end
   end

   // power-up reset is the only clear of serial flag, code and wait time
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q_q <= '0;
      end else begin
         q_q <= q_d;
      end
   end

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         xfer_req_o[c]      = q_q.ch[c].req;
         xfer_kind_o[c]     = q_q.ch[c].kind;
         xfer_func_o[c]     = q_q.ch[c].func;
         xfer_dir_o[c]      = q_q.ch[c].dir;
         resp_wait_o[c]     = q_q.ch[c].resp_wait;
         ser_err_o[c]       = q_q.ch[c].ser_err;
         busy_o[c]          = q_q.ch[c].busy;
         drv_err_o[c]       = q_q.ch[c].drv_err;
         drv_err_latch_o[c] = q_q.ch[c].drv_lat;
         bulk_err_o[c]      = q_q.ch[c].bulk_err;
      end
      done_o          = q_q.done;
      avs_readdata    = q_q.rdata;
      avs_waitrequest = ~q_q.wait_n;
   end

endmodule

//--- dcis_pkg.sv
// dcis_pkg: constants, types and register map of the drive command sequencer
package dcis_pkg;

   // channel and command-slot counts
   localparam int NCH   = 2;
   localparam int NSLOT = 4;
   localparam int SLW   = 2;

   // command types, function codes run consecutively from the base
   typedef enum logic [2:0] {
      CMD_MONITOR      = 3'b000,
      CMD_CONTROL      = 3'b001,
      CMD_PARAM_READ   = 3'b010,
      CMD_PARAM_WRITE  = 3'b011,
      CMD_BULK_WRITE   = 3'b100,
      CMD_CTRL_MONITOR = 3'b101
   } dcis_cmd_t;
   localparam logic [15:0] FUNC_CODE_BASE = 16'h010E;

   // transfer direction bits
   localparam int DIR_TO_DRIVE   = 0;
   localparam int DIR_FROM_DRIVE = 1;

   // channel sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PORT = 2'b01,
      ST_XFER = 2'b10
   } dcis_state_t;

   // port settle time before a transfer
   localparam int PORT_WAIT_US = 15000;
   localparam int CLK_MHZ      = 100;
   localparam int PORT_WAIT_CYC_DEF = PORT_WAIT_US * CLK_MHZ;
   localparam int TMR_W        = 21;

   // line error codes written per channel (decimal 6301 and 3801)
   localparam logic [15:0] LINE_ERR_CODE_CH1 = 16'h189D;
   localparam logic [15:0] LINE_ERR_CODE_CH2 = 16'h0ED9;

   // operation mode display values
   localparam logic [15:0] MODE_NONE  = 16'h0000;
   localparam logic [15:0] MODE_DRIVE = 16'h0006;

   // reset values
   localparam logic [15:0] WORD_RST = 16'h0000;

   // register map, byte offsets within a channel; channel 2 adds CH_STRIDE
   localparam logic [5:0] CH_STRIDE      = 6'h20;
   localparam logic [4:0] OFF_STATUS     = 5'h00;
   localparam logic [4:0] OFF_SER_CODE   = 5'h04;
   localparam logic [4:0] OFF_RESP_WAIT  = 5'h08;
   localparam logic [4:0] OFF_ACT_STEP   = 5'h0C;
   localparam logic [4:0] OFF_DRV_CODE   = 5'h10;
   localparam logic [4:0] OFF_ERR_STEP   = 5'h14;
   localparam logic [4:0] OFF_BULK_PARAM = 5'h18;
   localparam logic [4:0] OFF_MODE       = 5'h1C;

   // status register bit positions
   localparam int ST_BIT_DONE     = 0;
   localparam int ST_BIT_SER_ERR  = 1;
   localparam int ST_BIT_BUSY     = 2;
   localparam int ST_BIT_DRV_ERR  = 3;
   localparam int ST_BIT_DRV_LAT  = 4;
   localparam int ST_BIT_BULK_ERR = 5;

endpackage

//--- dcis_drive_model.sv
// dcis_drive_model: behavioural motor drive answering transfer requests
`timescale 1ns/1ps
module dcis_drive_model
   import dcis_pkg::*;
(
   // clock and reset
   input  wire logic                 ref_clk_i,
   input  wire logic                 sys_rst_i,
   // request side and bench controls
   input  wire logic [NCH-1:0]       req_i,
   input  wire logic [NCH-1:0]       slow_i,
   input  wire logic [NCH-1:0]       fail_i,
   input  wire logic [NCH-1:0][15:0] code_i,
   // answer side
   output logic      [NCH-1:0]       done_o,
   output logic      [NCH-1:0]       err_o,
   output logic      [NCH-1:0][15:0] err_code_o,
   output logic      [NCH-1:0][15:0] err_param_o
);
   logic [NCH-1:0][4:0] cnt_q;
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q  <= '0;
         done_o <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            // one answer per request: the count restarts only after the answer
            cnt_q[c]  <= (req_i[c] && !done_o[c]) ? cnt_q[c] + 5'h01 : 5'h00;
            done_o[c] <= req_i[c] && !done_o[c] && cnt_q[c] == (slow_i[c] ? 5'h0C : 5'h02);
         end
      end
   end
   for (genvar c = 0; c < NCH; c++) begin : g_out
      // outside the answer cycle the lines carry junk so a stale sample shows
      assign err_o[c]       = done_o[c] ? fail_i[c] : ~fail_i[c];
      assign err_code_o[c]  = done_o[c] ? code_i[c] : ~code_i[c];
      assign err_param_o[c] = done_o[c] ? {code_i[c][7:0], code_i[c][15:8]} : ~code_i[c];
   end
endmodule

//--- dcis_checker.sv
// dcis_checker: concurrent checks on the drive command sequencer ports
`timescale 1ns/1ps
module dcis_checker
   import dcis_pkg::*;
#(
   parameter int PORT_WAIT_CYC = 8
) (
   input wire logic                 ref_clk_i,
   input wire logic                 sys_rst_i,
   input wire logic                 scan_end_i,
   input wire logic [NCH-1:0]       xfer_done_i,
   input wire logic [NCH-1:0]       xfer_err_i,
   input wire logic [NCH-1:0]       line_err_i,
   input wire logic                 avs_read,
   input wire logic                 avs_write,
   input wire logic                 avs_waitrequest,
   input wire logic                 done_o,
   input wire logic [NCH-1:0]       xfer_req_o,
   input wire dcis_cmd_t [NCH-1:0]  xfer_kind_o,
   input wire logic [NCH-1:0][15:0] xfer_func_o,
   input wire logic [NCH-1:0][1:0]  xfer_dir_o,
   input wire logic [NCH-1:0]       busy_o,
   input wire logic [NCH-1:0]       drv_err_o,
   input wire logic [NCH-1:0]       drv_err_latch_o,
   input wire logic [NCH-1:0]       bulk_err_o,
   input wire logic [NCH-1:0]       ser_err_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   // cycles spent busy before the request, per channel
   logic [NCH-1:0][TMR_W-1:0] wcnt_q;
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wcnt_q <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            wcnt_q[c] <= (busy_o[c] && !xfer_req_o[c]) ? wcnt_q[c] + 1'b1 : '0;
         end
      end
   end
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      a_busy_span: assert property (xfer_req_o[c] |-> busy_o[c])
         else $error("busy low during transfer");
      a_port_wait: assert property ($rose(xfer_req_o[c]) |-> wcnt_q[c] == PORT_WAIT_CYC)
         else $error("port wait length wrong");
      a_end_release: assert property (xfer_req_o[c] && xfer_done_i[c] |=> !xfer_req_o[c])
         else $error("request kept after done");
      a_err_pair: assert property (xfer_req_o[c] && xfer_done_i[c] && xfer_err_i[c]
         |=> drv_err_o[c] && drv_err_latch_o[c])
         else $error("drive error flags not set");
      a_bulk_flag: assert property (xfer_req_o[c] && xfer_done_i[c] && xfer_err_i[c]
         && xfer_kind_o[c] == CMD_BULK_WRITE |=> bulk_err_o[c])
         else $error("bulk error flag not set");
      a_line_only: assert property (line_err_i[c] && !xfer_req_o[c]
         |=> ser_err_o[c] && $stable(drv_err_o[c]))
         else $error("line error flag handling wrong");
      a_func_code: assert property (xfer_req_o[c]
         |-> xfer_func_o[c] == FUNC_CODE_BASE + {13'h0000, xfer_kind_o[c]})
         else $error("function code wrong");
      a_dir_kind: assert property (xfer_req_o[c] |->
         xfer_dir_o[c][DIR_FROM_DRIVE] ==
         (xfer_kind_o[c] inside {CMD_MONITOR, CMD_PARAM_READ, CMD_CTRL_MONITOR}) &&
         xfer_dir_o[c][DIR_TO_DRIVE] ==
         !(xfer_kind_o[c] inside {CMD_MONITOR, CMD_PARAM_READ}))
         else $error("direction wrong");
      a_done_err: assert property (xfer_req_o[c] && xfer_done_i[c] && xfer_err_i[c]
         |-> ##[1:40] done_o)
         else $error("no done after error");
   end
   a_done_start: assert property ($rose(done_o) |-> $past(scan_end_i))
      else $error("done rose off scan end");
   a_done_hold: assert property (done_o && !scan_end_i |=> done_o)
      else $error("done dropped mid scan");
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus answer late");
   c_done: cover property (done_o && scan_end_i);
   c_bulk: cover property (|bulk_err_o);
   c_line: cover property (line_err_i[1]);
endmodule
bind dcis_top dcis_checker #(.PORT_WAIT_CYC(PORT_WAIT_CYC)) u_chk (.*);

//--- tb_top.sv
// tb_top: directed bench for the drive command sequencer
`timescale 1ns/1ps
module tb_top;
   import dcis_pkg::*;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   localparam logic [31:0] FLG = 32'h0000_003E;
   logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, run_mode_i = 1'b1, scan_end_i = 1'b0;
   logic [NCH-1:0][NSLOT-1:0] drive_i = '0;
   dcis_cmd_t [NCH-1:0][NSLOT-1:0] cmd_kind_i;
   logic [NCH-1:0][NSLOT-1:0][15:0] cmd_step_i = '0;
   logic [NCH-1:0] line_err_i = '0, drv_slow = '1, drv_fail = '0;
   logic [NCH-1:0] xfer_done_i, xfer_err_i, xfer_req_o;
   logic [NCH-1:0][15:0] drv_code = '0, xfer_err_code_i, xfer_err_param_i;
   logic [NCH-1:0][15:0] xfer_func_o, resp_wait_o;
   dcis_cmd_t [NCH-1:0] xfer_kind_o;
   logic done_o, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
   logic [3:0] avs_byteenable = 4'h3;
   logic [3:0] scan_q = 4'h0;
   int miscompares = 0, n_checks = 0;
   dcis_top #(.PORT_WAIT_CYC(8)) uut (.*, .xfer_dir_o(), .ser_err_o(), .busy_o(), .drv_err_o(),
      .drv_err_latch_o(), .bulk_err_o());
   dcis_drive_model u_drv (.ref_clk_i, .sys_rst_i, .req_i(xfer_req_o), .slow_i(drv_slow),
      .fail_i(drv_fail), .code_i(drv_code), .done_o(xfer_done_i), .err_o(xfer_err_i),
      .err_code_o(xfer_err_code_i), .err_param_o(xfer_err_param_i));
   always #5 ref_clk_i = ~ref_clk_i;
   // a short program scan keeps the done pulse windows small
   always @(posedge ref_clk_i) begin
      scan_q <= scan_q + 4'h1;
      scan_end_i <= (scan_q == 4'hF);
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stall(input string what);
      check(what, 32'h0000_0000, 32'h0000_0001);
      complete_run();
   endtask
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int i;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      @(posedge ref_clk_i);
      for (i = 0; i < 50 && avs_waitrequest !== 1'b0; i++) begin
         @(posedge ref_clk_i);
      end
      if (i == 50) stall("bus answer");
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // one idle edge so the next call never reassigns a strobe in this step
      @(posedge ref_clk_i);
   endtask
   task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0000_0000, rd);
      check(what, rd & m, exp);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, rd);
   endtask
   task automatic wait_req(input int c, input logic lvl);
      int i;
      for (i = 0; i < 100 && xfer_req_o[c] !== lvl; i++) begin
         @(posedge ref_clk_i);
      end
      if (i == 100) stall("transfer request");
   endtask
   task automatic wait_done();
      int i;
      for (i = 0; i < 40 && done_o !== 1'b1; i++) begin
         @(posedge ref_clk_i);
      end
      if (i == 40) stall("done pulse");
      check("done pulse", {31'h0000_0000, done_o}, 32'h0000_0001);
      for (i = 0; i < 40 && done_o !== 1'b0; i++) begin
         @(posedge ref_clk_i);
      end
      if (i == 40) stall("done end");
   endtask
   task automatic run_cmd(input int c, input int s, input dcis_cmd_t k, input logic [15:0] st,
                          input logic f, input logic [15:0] code);
      cmd_kind_i[c][s] <= k;
      cmd_step_i[c][s] <= st;
      drv_fail[c] <= f;
      drv_code[c] <= code;
      @(posedge ref_clk_i);
      drive_i[c][s] <= 1'b1;
      wait_req(c, 1'b1);
      check("function code", 32'(xfer_func_o[c]), 32'(FUNC_CODE_BASE + 16'(k)));
      if (drv_slow[c]) rchk("active step", {c[0], OFF_ACT_STEP}, ALL, 32'(st));
      drive_i[c][s] <= 1'b0;
      wait_req(c, 1'b0);
      wait_done();
   endtask
   initial begin
      cmd_kind_i = '{default: CMD_MONITOR};
      repeat (2) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      rchk("mode idle", {1'b0, OFF_MODE}, ALL, 32'(MODE_NONE));
      rchk("unmapped", 6'h3E, ALL, 32'h0000_0000);
      wr({1'b0, OFF_RESP_WAIT}, 32'h0000_00C8);
      wr({1'b1, OFF_RESP_WAIT}, 32'h0000_0033);
      wr({1'b0, OFF_SER_CODE}, 32'h0000_FFFF);
      rchk("wait time", {1'b0, OFF_RESP_WAIT}, ALL, 32'h0000_00C8);
      check("wait port", 32'(resp_wait_o[1]), 32'h0000_0033);
      rchk("ro code", {1'b0, OFF_SER_CODE}, ALL, 32'h0000_0000);
      for (int k = 0; k < 6; k++) begin
         drv_slow[1] <= (k < 3);
         run_cmd(1, 0, dcis_cmd_t'(k), 16'h0100 + 16'(k), 1'b0, 16'h0000);
      end
      rchk("mode drive", {1'b1, OFF_MODE}, ALL, 32'(MODE_DRIVE));
      rchk("ch2 clean", {1'b1, OFF_STATUS}, FLG, 32'h0000_0000);
      run_cmd(0, 0, CMD_BULK_WRITE, 16'h0040, 1'b1, 16'h1234);
      rchk("err flags", {1'b0, OFF_STATUS}, FLG, 32'h0000_003A);
      rchk("bulk param", {1'b0, OFF_BULK_PARAM}, ALL, 32'h0000_3412);
      run_cmd(0, 1, CMD_PARAM_READ, 16'h0041, 1'b1, 16'h0055);
      rchk("drive code", {1'b0, OFF_DRV_CODE}, ALL, 32'h0000_0055);
      rchk("first step", {1'b0, OFF_ERR_STEP}, ALL, 32'h0000_0040);
      drv_fail[0] <= 1'b0;
      cmd_kind_i[0][2] <= CMD_CONTROL;
      cmd_kind_i[0][3] <= CMD_PARAM_WRITE;
      cmd_step_i[0][3] <= 16'h0077;
      @(posedge ref_clk_i);
      drive_i[0][3:2] <= 2'b11;
      wait_req(0, 1'b1);
      check("first kind", 32'(xfer_kind_o[0]), 32'(CMD_CONTROL));
      drive_i[0][2] <= 1'b0;
      for (int n = 0; n < 2; n++) begin
         wait_req(0, 1'b0);
         wait_req(0, 1'b1);
         check("queued kind", 32'(xfer_kind_o[0]), 32'(CMD_PARAM_WRITE));
         rchk("queued step", {1'b0, OFF_ACT_STEP}, ALL, 32'h0000_0077);
      end
      drive_i[0][3] <= 1'b0;
      wait_req(0, 1'b0);
      wait_done();
      line_err_i <= 2'b11;
      @(posedge ref_clk_i);
      line_err_i <= 2'b00;
      rchk("line flags", {1'b1, OFF_STATUS}, FLG, 32'h0000_0002);
      rchk("line code 2", {1'b1, OFF_SER_CODE}, ALL, 32'(LINE_ERR_CODE_CH2));
      run_mode_i <= 1'b0;
      @(posedge ref_clk_i);
      run_mode_i <= 1'b1;
      @(posedge ref_clk_i);
      rchk("after run", {1'b0, OFF_STATUS}, FLG, 32'h0000_0002);
      rchk("line code 1", {1'b0, OFF_SER_CODE}, ALL, 32'(LINE_ERR_CODE_CH1));
      rchk("kept wait", {1'b0, OFF_RESP_WAIT}, ALL, 32'h0000_00C8);
      rchk("cleared code", {1'b0, OFF_DRV_CODE}, ALL, 32'h0000_0000);
      rchk("cleared step", {1'b0, OFF_ERR_STEP}, ALL, 32'h0000_0000);
      rchk("cleared param", {1'b0, OFF_BULK_PARAM}, ALL, 32'h0000_0000);
      complete_run();
   end
endmodule
